// file: rtl/ata_idle_pkg.sv
// Constants for the identify tail words and the idle/abort command logic.
// Assumes a 50 MHz core clock and a task-file front end that hands over one command at a time.
package ata_idle_pkg;
    // Clock and timer base
    localparam int unsigned CLK_HZ        = 50_000_000;
    localparam int unsigned TICK_MS       = 5;
    localparam int unsigned TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
    // Command opcodes
    localparam logic [7:0] OP_IDLE_A      = 8'h97;
    localparam logic [7:0] OP_IDLE_B      = 8'he3;
    localparam logic [7:0] OP_IDLE_IMM_A  = 8'h95;
    localparam logic [7:0] OP_IDLE_IMM_B  = 8'he1;
    localparam logic [7:0] OP_MEDIA_LOCK  = 8'hde;
    localparam logic [7:0] OP_MEDIA_ULOCK = 8'hdf;
    localparam logic [7:0] OP_NOP         = 8'h00;
    // Identify word indices served here
    localparam logic [7:0] W_QDEPTH       = 8'd75;
    localparam logic [7:0] W_SATA_CAP     = 8'd76;
    localparam logic [7:0] W_SATA_SUP     = 8'd78;
    localparam logic [7:0] W_SATA_EN      = 8'd79;
    localparam logic [7:0] W_FEAT_SUP1    = 8'd82;
    localparam logic [7:0] W_FEAT_SUP2    = 8'd83;
    localparam logic [7:0] W_FEAT_SUP3    = 8'd84;
    localparam logic [7:0] W_FEAT_EN1     = 8'd85;
    localparam logic [7:0] W_FEAT_EN2     = 8'd86;
    localparam logic [7:0] W_FEAT_EN3     = 8'd87;
    localparam logic [7:0] W_UDMA         = 8'd88;
    localparam logic [7:0] W_ERASE_TIME   = 8'd89;
    localparam logic [7:0] W_MPW_REV      = 8'd92;
    localparam logic [7:0] W_SEC_STAT     = 8'd128;
    localparam logic [7:0] W_WP_STAT      = 8'd129;
    // Fixed bit patterns
    localparam logic [15:0] VALID_MARK    = 16'h4000;
    localparam logic [15:0] FEAT1_FIXED   = 16'h7008;
    localparam int unsigned B_SEC         = 1;
    localparam int unsigned B_WCACHE      = 5;
    localparam int unsigned B_LOOKAHEAD   = 6;
    localparam int unsigned B_APM         = 3;
    localparam int unsigned B_PHY_EVT     = 10;
    localparam int unsigned B_HIPM        = 9;
    localparam int unsigned B_NCQ         = 8;
    localparam int unsigned B_GEN2        = 2;
    localparam int unsigned B_GEN1        = 1;
    localparam int unsigned B_SEC_MAX     = 8;
    localparam int unsigned B_SEC_ENH     = 5;
    localparam int unsigned B_SEC_EXP     = 4;
    localparam int unsigned B_SEC_FRZ     = 3;
    localparam int unsigned B_SEC_LCK     = 2;
    localparam int unsigned B_SEC_ENA     = 1;
    localparam int unsigned B_SEC_SUP     = 0;
    localparam int unsigned B_WP_SPARE    = 15;
    localparam int unsigned B_WP_TABLE    = 14;
    localparam int unsigned B_RP_TABLE    = 13;
    localparam int unsigned B_WP_PERM     = 9;
    localparam int unsigned B_WP_TEMP     = 8;
    // Status byte bits (abort error)
    localparam logic [7:0] ERR_ABORT      = 8'h04;
endpackage

// file: rtl/ident_word_rom.sv
// Registered identify-word lookup for the tail words of the parameter block.
// Assumes all configuration inputs are synchronous to core_clk_in.
module ident_word_rom (
    input  wire logic        core_clk_in,
    input  wire logic        ce_in,
    input  wire logic [7:0]  word_idx_in,
    input  wire logic [4:0]  qdepth_m1_in,
    input  wire logic [2:0]  sata_cap_in,
    input  wire logic [5:0]  sata_sup_in,
    input  wire logic [5:0]  sata_en_in,
    input  wire logic [2:0]  feat_sup_in,
    input  wire logic [2:0]  feat_en_in,
    input  wire logic        apm_sup_in,
    input  wire logic        apm_en_in,
    input  wire logic        udma_sup_in,
    input  wire logic [2:0]  udma_top_in,
    input  wire logic        udma_sel_in,
    input  wire logic [2:0]  udma_mode_in,
    input  wire logic [15:0] erase_half_min_in,
    input  wire logic [15:0] mpw_rev_in,
    input  wire logic [15:0] sec_stat_in,
    input  wire logic [4:0]  wp_stat_in,
    output logic      [15:0] word_out
);
    logic [15:0] w;
    logic [6:0]  udma_support;
    logic [6:0]  udma_select;

    always_comb begin
        // Cumulative support mask and one-hot selection
        udma_support = 7'h7f >> (3'd6 - udma_top_in);
        udma_select  = udma_sel_in ? (7'h01 << udma_mode_in) : 7'h00;
        if (udma_mode_in > udma_top_in)
            udma_select = 7'h00;
        w = 16'h0000;
        case (word_idx_in)
            ata_idle_pkg::W_QDEPTH:     w = {11'h000, qdepth_m1_in};
            // link capability
            // Both signalling rates are always offered
            ata_idle_pkg::W_SATA_CAP:   w = {5'h00, sata_cap_in, 5'h00, 2'h3, 1'b0};
            ata_idle_pkg::W_SATA_SUP:   w = {9'h000, sata_sup_in, 1'b0};
            // link features enabled, limited to supported
            ata_idle_pkg::W_SATA_EN:    w = {9'h000, sata_en_in & sata_sup_in, 1'b0};
            ata_idle_pkg::W_FEAT_SUP1:  w = ata_idle_pkg::FEAT1_FIXED | {9'h000, feat_sup_in[2:1], 3'h0, feat_sup_in[0], 1'b0};
            ata_idle_pkg::W_FEAT_SUP2:  w = ata_idle_pkg::VALID_MARK | {12'h000, apm_sup_in, 3'h0};
            ata_idle_pkg::W_FEAT_SUP3:  w = ata_idle_pkg::VALID_MARK;
            ata_idle_pkg::W_FEAT_EN1:   w = ata_idle_pkg::FEAT1_FIXED
                                            | {9'h000, feat_en_in[2:1] & feat_sup_in[2:1], 3'h0,
                                               feat_en_in[0] & feat_sup_in[0], 1'b0};
            ata_idle_pkg::W_FEAT_EN2:   w = {12'h000, apm_en_in & apm_sup_in, 3'h0};
            ata_idle_pkg::W_FEAT_EN3:   w = ata_idle_pkg::VALID_MARK;
            ata_idle_pkg::W_UDMA:       w = udma_sup_in ? {1'b0, udma_select, 1'b0, udma_support} : 16'h0000;
            ata_idle_pkg::W_ERASE_TIME: w = erase_half_min_in;
            ata_idle_pkg::W_MPW_REV:    w = mpw_rev_in;
            ata_idle_pkg::W_SEC_STAT:   w = sec_stat_in;
            ata_idle_pkg::W_WP_STAT:    w = {wp_stat_in[4:2], 3'h0, wp_stat_in[1:0], 8'h00};
            default:                    w = 16'h0000;
        endcase
    end

    always_ff @(posedge core_clk_in) begin
        if (ce_in)
            word_out <= w;
    end

    a_udma_onehot: assert property (@(posedge core_clk_in)
        $past(word_idx_in) == ata_idle_pkg::W_UDMA && $past(ce_in) |-> $onehot0(word_out[14:8]))
        else $error("ultra dma selection not one-hot");
    a_udma_cumulative: assert property (@(posedge core_clk_in)
        $past(word_idx_in) == ata_idle_pkg::W_UDMA && $past(ce_in)
        |-> (word_out[6:0] & (word_out[6:0] + 7'h01)) == 7'h00)
        else $error("ultra dma support not cumulative");
endmodule

// file: rtl/ata_identify_idle_cmd_logic.sv
// Identify tail words, idle commands with auto power-down timer, and aborted no-op commands.
// Assumes a task-file front end on the same clock that pulses cmd_valid_in once per command.
// Overview of operation
// - Word 75 reports queue depth minus one in bits 4:0.
// - Word 76 flags phy events, host power requests, queuing, 3.0 and 1.5 rates.
// - Word 78 flags six link features in bits 6:1, bit 0 zero.
// - Word 79 shows enabled link features in the same positions.
// - Supported words two and three carry bit 14 set, bit 15 clear.
// - First supported word sets bits 3,12,13,14 and clears listed unsupported bits.
// - Bits 1,5,6 flag security, write cache, look-ahead support.
// - Second supported word clears bits 0,1,2,4; bit 3 flags power-level control.
// - Third enabled word sets bit 14, clears bit 15, rest zero.
// - Enabled words 85 and 87 mirror fixed bits; 85 and 86 add security, cache, look-ahead, power-level state.
// - Ultra DMA selection is one-hot in bits 14:8, exclusive with multiword.
// - Ultra DMA support bits are cumulative; word is zero when unsupported.
// - Word 89 holds erase minutes divided by two.
// - Word 92 holds master password revision code.
// - Security level bit 8 set only when enabled at maximum.
// - Security word reports enhanced erase, frozen, locked, enabled, supported.
// - Expired unlock count sets bit 4 and aborts unlock and erase until reset.
// - Word 129 reports vendor write and read protection flags.
// - Idle commands: set busy, enter idle, clear busy, raise interrupt.
// - Idle (not idle immediate) count: nonzero arms power-down after count times 5 ms; zero disarms.
// - Media lock and unlock do nothing and abort.
// - No-op command always aborts.
module ata_identify_idle_cmd_logic #(
    parameter int unsigned TICK_CYCLES = ata_idle_pkg::TICK_CYCLES
) (
    input  wire logic        core_clk_in,
    input  wire logic        rstn_in,
    input  wire logic        ce_in,
    input  wire logic        cmd_valid_in,
    input  wire logic [7:0]  cmd_opcode_in,
    input  wire logic [7:0]  cmd_count_in,
    input  wire logic        host_activity_in,
    input  wire logic [7:0]  word_idx_in,
    input  wire logic [4:0]  qdepth_m1_in,
    input  wire logic [2:0]  sata_cap_in,
    input  wire logic [5:0]  sata_sup_in,
    input  wire logic [5:0]  sata_en_in,
    input  wire logic [2:0]  feat_sup_in,
    input  wire logic [2:0]  feat_en_in,
    input  wire logic        apm_sup_in,
    input  wire logic        apm_en_in,
    input  wire logic        udma_sup_in,
    input  wire logic [2:0]  udma_top_in,
    input  wire logic        udma_sel_in,
    input  wire logic [2:0]  udma_mode_in,
    input  wire logic [15:0] erase_half_min_in,
    input  wire logic [15:0] mpw_rev_in,
    input  wire logic        sec_sup_in,
    input  wire logic        sec_enh_in,
    input  wire logic        sec_en_in,
    input  wire logic        sec_max_in,
    input  wire logic        sec_lock_in,
    input  wire logic        sec_frozen_in,
    input  wire logic        unlock_fail_in,
    input  wire logic        sec_cmd_in,
    input  wire logic [4:0]  wp_stat_in,
    output logic      [15:0] word_out,
    output logic             drive_occupied_flag_out,
    output logic             cmd_done_out,
    output logic             cmd_abort_out,
    output logic      [7:0]  err_out,
    output logic             intrq_out,
    output logic             idle_mode_out,
    output logic             standby_req_out,
    output logic             sec_expired_out
);
    // Refuse a tick length the countdown cannot serve
    if (TICK_CYCLES < 1) begin : g_bad_tick
        $error("TICK_CYCLES must be at least one");
    end

    typedef enum logic [3:0] {
        ST_READY = 4'b0001,
        ST_BUSY  = 4'b0010,
        ST_DONE  = 4'b0100,
        ST_ABORT = 4'b1000
    } cmd_state_t;

    typedef struct packed {
        cmd_state_t  st;
        logic        occupied;
        logic        done;
        logic        abort;
        logic [7:0]  err;
        logic        intrq;
        logic        idle;
        logic        standby;
        logic        apd_en;
        logic [7:0]  apd_units;
        logic [7:0]  unit_cnt;
        logic [31:0] tick_cnt;
        logic        expired;
        logic        arm_pending;
        logic [7:0]  arm_count;
    } state_t;

    state_t s;
    state_t next_s;
    logic   is_idle;
    logic   is_idle_imm;
    logic   is_abort_op;
    logic   sec_abort;
    logic [15:0] sec_word;

    always_comb begin
        is_idle     = (cmd_opcode_in == ata_idle_pkg::OP_IDLE_A) || (cmd_opcode_in == ata_idle_pkg::OP_IDLE_B);
        is_idle_imm = (cmd_opcode_in == ata_idle_pkg::OP_IDLE_IMM_A)
                   || (cmd_opcode_in == ata_idle_pkg::OP_IDLE_IMM_B);
        is_abort_op = (cmd_opcode_in == ata_idle_pkg::OP_MEDIA_LOCK)
                   || (cmd_opcode_in == ata_idle_pkg::OP_MEDIA_ULOCK)
                   || (cmd_opcode_in == ata_idle_pkg::OP_NOP);
        sec_abort   = sec_cmd_in && s.expired;
        sec_word = 16'h0000;
        sec_word[ata_idle_pkg::B_SEC_SUP] = sec_sup_in;
        sec_word[ata_idle_pkg::B_SEC_ENA] = sec_en_in;
        sec_word[ata_idle_pkg::B_SEC_LCK] = sec_lock_in;
        sec_word[ata_idle_pkg::B_SEC_FRZ] = sec_frozen_in;
        sec_word[ata_idle_pkg::B_SEC_EXP] = s.expired;
        sec_word[ata_idle_pkg::B_SEC_ENH] = sec_enh_in;
        sec_word[ata_idle_pkg::B_SEC_MAX] = sec_en_in & sec_max_in;
    end

    always_comb begin
        next_s = s;
        next_s.done  = 1'b0;
        next_s.abort = 1'b0;
        if (unlock_fail_in)
            next_s.expired = 1'b1;
        // Auto power-down countdown, restarted by host activity
        if (host_activity_in) begin
            next_s.standby  = 1'b0;
            next_s.tick_cnt = 32'd0;
            next_s.unit_cnt = 8'd0;
        end else if (s.apd_en && !s.standby) begin
            if (s.tick_cnt == 32'(TICK_CYCLES - 1)) begin
                next_s.tick_cnt = 32'd0;
                if (s.unit_cnt == s.apd_units - 8'd1) begin
                    next_s.standby  = 1'b1;
                    next_s.idle     = 1'b0;
                    next_s.unit_cnt = 8'd0;
                end else begin
                    next_s.unit_cnt = s.unit_cnt + 8'd1;
                end
            end else begin
                next_s.tick_cnt = s.tick_cnt + 32'd1;
            end
        end
        case (s.st)
            ST_READY: begin
                if (cmd_valid_in) begin
                    next_s.intrq = 1'b0;
                    if (is_idle || is_idle_imm) begin
                        next_s.occupied    = 1'b1;
                        next_s.st          = ST_BUSY;
                        next_s.arm_pending = is_idle;
                        next_s.arm_count   = cmd_count_in;
                    end else if (is_abort_op || sec_abort) begin
                        next_s.occupied = 1'b1;
                        next_s.st       = ST_ABORT;
                    end
                end
            end
            ST_BUSY: begin
                next_s.idle     = 1'b1;
                next_s.standby  = 1'b0;
                next_s.tick_cnt = 32'd0;
                next_s.unit_cnt = 8'd0;
                if (s.arm_pending) begin
                    next_s.apd_en    = (s.arm_count != 8'd0);
                    next_s.apd_units = s.arm_count;
                end
                next_s.st = ST_DONE;
            end
            ST_DONE: begin
                next_s.occupied = 1'b0;
                next_s.done     = 1'b1;
                next_s.err      = 8'h00;
                next_s.intrq    = 1'b1;
                next_s.st       = ST_READY;
            end
            ST_ABORT: begin
                next_s.occupied = 1'b0;
                next_s.abort    = 1'b1;
                next_s.err      = ata_idle_pkg::ERR_ABORT;
                next_s.intrq    = 1'b1;
                next_s.st       = ST_READY;
            end
            default: next_s.st = ST_READY;
        endcase
    end

    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            s <= '{st: ST_READY, default: '0};
        end else if (ce_in) begin
            s <= next_s;
        end
    end

    ident_word_rom u_rom (
        .core_clk_in       (core_clk_in),
        .ce_in             (ce_in),
        .word_idx_in       (word_idx_in),
        .qdepth_m1_in      (qdepth_m1_in),
        .sata_cap_in       (sata_cap_in),
        .sata_sup_in       (sata_sup_in),
        .sata_en_in        (sata_en_in),
        .feat_sup_in       ({feat_sup_in[2:1], feat_sup_in[0] & sec_sup_in}),
        .feat_en_in        ({feat_en_in[2:1], sec_en_in}),
        .apm_sup_in        (apm_sup_in),
        .apm_en_in         (apm_en_in),
        .udma_sup_in       (udma_sup_in),
        .udma_top_in       (udma_top_in),
        .udma_sel_in       (udma_sel_in),
        .udma_mode_in      (udma_mode_in),
        .erase_half_min_in (erase_half_min_in),
        .mpw_rev_in        (mpw_rev_in),
        .sec_stat_in       (sec_word),
        .wp_stat_in        (wp_stat_in),
        .word_out          (word_out)
    );

    assign drive_occupied_flag_out = s.occupied;
    assign cmd_done_out            = s.done;
    assign cmd_abort_out           = s.abort;
    assign err_out                 = s.err;
    assign intrq_out               = s.intrq;
    assign idle_mode_out           = s.idle;
    assign standby_req_out         = s.standby;
    assign sec_expired_out         = s.expired;

    sequence seq_idle_start;
        cmd_valid_in && (is_idle || is_idle_imm) && s.st == ST_READY && ce_in;
    endsequence
    sequence seq_abort_start;
        cmd_valid_in && is_abort_op && s.st == ST_READY && ce_in;
    endsequence
    sequence seq_idle_steps;
        drive_occupied_flag_out ##1 idle_mode_out ##1 (cmd_done_out && intrq_out && !drive_occupied_flag_out);
    endsequence

    a_idle_busy_seq: assert property (@(posedge core_clk_in) disable iff (!rstn_in || !ce_in)
        seq_idle_start |=> seq_idle_steps)
        else $error("idle sequence wrong");
    a_abort_seq: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        seq_abort_start ##1 ce_in |-> drive_occupied_flag_out ##1 (cmd_abort_out && err_out == 8'h04))
        else $error("abort missing");
    a_nop_abort: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        cmd_valid_in && cmd_opcode_in == 8'h00 && s.st == ST_READY && ce_in ##1 ce_in |-> ##1 cmd_abort_out)
        else $error("nop not aborted");
    a_expired_sticky: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        sec_expired_out |=> sec_expired_out)
        else $error("expiry cleared");
    a_expired_abort: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        cmd_valid_in && sec_cmd_in && sec_expired_out && s.st == ST_READY && ce_in ##1 ce_in |-> ##1 cmd_abort_out)
        else $error("expired unlock not aborted");
    a_apd_disable: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        s.st == ST_BUSY && s.arm_pending && s.arm_count == 8'h00 && ce_in |=> !s.apd_en)
        else $error("zero count left timer on");
    a_apd_arm: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        s.st == ST_BUSY && s.arm_pending && s.arm_count != 8'h00 && ce_in |=> s.apd_en && s.apd_units == $past(s.arm_count))
        else $error("timer not armed");
    a_sec_max: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        !sec_en_in |-> !sec_word[8])
        else $error("max level without enable");
    a_word_valid: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        word_idx_in == 8'd87 && ce_in |=> word_out == 16'h4000)
        else $error("word 87 wrong");
    a_finish_release: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        cmd_done_out || cmd_abort_out |-> !drive_occupied_flag_out && intrq_out)
        else $error("completion without busy release or interrupt");
    a_done_pulse: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        cmd_done_out && ce_in |=> !cmd_done_out)
        else $error("done held longer than one cycle");
    a_standby_idle: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        standby_req_out |-> !idle_mode_out)
        else $error("standby while still idle");
endmodule

// file: verification/host_cmd_model.sv
// Host model that issues one task-file command at a time to the device.
// Assumes the device samples the strobe on the rising edge of core_clk_in.
module host_cmd_model (
    input  wire logic       core_clk_in,
    output logic            cmd_valid_out,
    output logic      [7:0] cmd_opcode_out,
    output logic      [7:0] cmd_count_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cmd_valid_out = 1'b0;
        cmd_opcode_out = 8'h5a;
        cmd_count_out = 8'ha5;
    end
    task automatic send(input logic [7:0] op, input logic [7:0] cnt);
        @(posedge core_clk_in);
        #1;
        cmd_valid_out = 1'b1;
        cmd_opcode_out = op;
        cmd_count_out = cnt;
        @(posedge core_clk_in);
        #1;
        cmd_valid_out = 1'b0;
        cmd_opcode_out = ~op;
        cmd_count_out = ~cnt;
    endtask
endmodule

// file: verification/ata_identify_idle_cmd_logic_tb_top.sv
// Self-checking bench for identify tail words, idle and aborted commands.
// Assumes host_cmd_model drives the command strobe; power-down tick shortened.
module ata_identify_idle_cmd_logic_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned TICKS = 4;
    logic        core_clk_in, rstn_in, host_activity_in, cmd_valid_in, apm_sup_in, apm_en_in, udma_sup_in, udma_sel_in;
    logic        sec_sup_in, sec_enh_in, sec_en_in, sec_max_in, sec_lock_in, sec_frozen_in, unlock_fail_in, sec_cmd_in;
    logic [7:0]  cmd_opcode_in, cmd_count_in, word_idx_in, err_out;
    logic [4:0]  qdepth_m1_in, wp_stat_in;
    logic [2:0]  sata_cap_in, feat_sup_in, feat_en_in, udma_top_in, udma_mode_in;
    logic [5:0]  sata_sup_in, sata_en_in;
    logic [15:0] erase_half_min_in, mpw_rev_in, word_out;
    logic        drive_occupied_flag_out, cmd_done_out, cmd_abort_out, intrq_out, idle_mode_out, standby_req_out;
    logic        sec_expired_out;
    logic        ce_in;
    int          miscompares = 0;
    int          samples_checked = 0;

    host_cmd_model host (.core_clk_in, .cmd_valid_out(cmd_valid_in), .cmd_opcode_out(cmd_opcode_in),
        .cmd_count_out(cmd_count_in));
    ata_identify_idle_cmd_logic #(.TICK_CYCLES(TICKS)) u_dut (.core_clk_in, .rstn_in, .ce_in, .cmd_valid_in,
        .cmd_opcode_in, .cmd_count_in, .host_activity_in, .word_idx_in, .qdepth_m1_in, .sata_cap_in, .sata_sup_in,
        .sata_en_in, .feat_sup_in, .feat_en_in, .apm_sup_in, .apm_en_in, .udma_sup_in, .udma_top_in, .udma_sel_in,
        .udma_mode_in, .erase_half_min_in, .mpw_rev_in, .sec_sup_in, .sec_enh_in, .sec_en_in, .sec_max_in,
        .sec_lock_in, .sec_frozen_in, .unlock_fail_in, .sec_cmd_in, .wp_stat_in, .word_out,
        .drive_occupied_flag_out, .cmd_done_out, .cmd_abort_out, .err_out, .intrq_out, .idle_mode_out,
        .standby_req_out, .sec_expired_out);

    initial begin
        core_clk_in = 1'b0;
        forever #10 core_clk_in = ~core_clk_in;
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge core_clk_in);
        #1;
    endtask
    task automatic rd(input logic [7:0] idx, input logic [15:0] exp);
        step(1);
        word_idx_in = idx;
        step(1);
        chk($sformatf("word %0d", idx), exp, word_out);
    endtask
    task automatic test_idle(input logic [7:0] op, input logic [7:0] cnt);
        int n;
        host.send(op, cnt);
        chk("busy", 1'b1, drive_occupied_flag_out);
        chk("intrq cleared", 1'b0, intrq_out);
        step(1);
        chk("idle mode", 1'b1, idle_mode_out);
        step(1);
        chk("done busy intrq err", 11'h500, {cmd_done_out, drive_occupied_flag_out, intrq_out, err_out});
        step(4);
        chk("standby early", 1'b0, standby_req_out);
        for (n = 0; n < 40 && standby_req_out !== 1'b1; n++) step(1);
        chk("standby", (cnt != 8'h00), standby_req_out);
        if (cnt != 8'h00) begin
            chk("standby delay", 16'(int'(cnt) * int'(TICKS) - 5), 16'(n));
            chk("idle left", 1'b0, idle_mode_out);
            host_activity_in = 1'b1;
            step(1);
            host_activity_in = 1'b0;
            step(1);
            chk("standby cleared", 1'b0, standby_req_out);
        end
        $display("test idle %h done", op);
    endtask
    task automatic test_abort(input logic [7:0] op);
        host.send(op, 8'h03);
        sec_cmd_in = 1'b0;
        chk("abort busy", 1'b1, drive_occupied_flag_out);
        step(1);
        chk("abort err", 11'h504, {cmd_abort_out, drive_occupied_flag_out, intrq_out, err_out});
        $display("test abort %h done", op);
    endtask
    task automatic test_ident();
        rd(8'd75, 16'h001f);
        rd(8'd76, 16'h0506);
        rd(8'd78, 16'h0056);
        rd(8'd79, 16'h0054);
        rd(8'd82, 16'h702a);
        rd(8'd83, 16'h4008);
        rd(8'd84, 16'h4000);
        rd(8'd85, 16'h702a);
        rd(8'd86, 16'h0008);
        rd(8'd87, 16'h4000);
        rd(8'd88, 16'h407f);
        rd(8'd89, 16'h00a5);
        rd(8'd92, 16'hfffe);
        rd(8'd128, 16'h0127);
        rd(8'd129, 16'ha100);
        ce_in = 1'b0;
        rd(8'd75, 16'ha100);
        ce_in = 1'b1;
        udma_top_in = 3'd2;
        udma_mode_in = 3'd0;
        rd(8'd88, 16'h0107);
        udma_sel_in = 1'b0;
        rd(8'd88, 16'h0007);
        udma_sup_in = 1'b0;
        rd(8'd88, 16'h0000);
        sec_en_in = 1'b0;
        rd(8'd128, 16'h0025);
        sec_en_in = 1'b1;
        $display("test identify done");
    endtask
    task automatic test_expire();
        unlock_fail_in = 1'b1;
        step(1);
        unlock_fail_in = 1'b0;
        step(1);
        chk("expired", 1'b1, sec_expired_out);
        rd(8'd128, 16'h0137);
        sec_cmd_in = 1'b1;
        test_abort(8'h55);
        rstn_in = 1'b0;
        step(1);
        rstn_in = 1'b1;
        chk("expired reset", 1'b0, sec_expired_out);
        $display("test expire done");
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        {rstn_in, host_activity_in, unlock_fail_in, sec_cmd_in, sec_frozen_in} = 5'h00;
        ce_in = 1'b1;
        {sec_sup_in, sec_enh_in, sec_en_in, sec_max_in, sec_lock_in} = 5'h1f;
        {apm_sup_in, apm_en_in, udma_sup_in, udma_sel_in} = 4'hf;
        {word_idx_in, qdepth_m1_in, wp_stat_in} = {8'd0, 5'h1f, 5'h15};
        {sata_cap_in, sata_sup_in, sata_en_in} = {3'h5, 6'h2b, 6'h3e};
        {feat_sup_in, feat_en_in, udma_top_in, udma_mode_in} = {3'h3, 3'h2, 3'h6, 3'h6};
        {erase_half_min_in, mpw_rev_in} = {16'h00a5, 16'hfffe};
        step(4);
        rstn_in = 1'b1;
        chk("reset outs", 16'h0, {drive_occupied_flag_out, cmd_done_out, cmd_abort_out, intrq_out, idle_mode_out,
            standby_req_out, sec_expired_out, err_out});
        test_ident();
        test_idle(8'h97, 8'h02);
        test_idle(8'he3, 8'h00);
        test_idle(8'h95, 8'h00);
        test_idle(8'he1, 8'h00);
        test_abort(8'hde);
        test_abort(8'hdf);
        test_abort(8'h00);
        test_expire();
        complete_run();
    end

    initial begin
        repeat (20000) @(posedge core_clk_in);
        miscompares++;
        complete_run();
    end
endmodule
